// ==== common/panel_timing_pkg.sv ====
// What this block does
// R01 - Link clock runs 60 to 80 MHz, nominally 74 MHz.
// R02 - Overdrive select high means frames at 47 to 53 Hz, nominally 50.
// R03 - Overdrive select low means frames at 57 to 63 Hz, nominally 60.
// R04 - Vertical total is 1115 to 1139 lines, nominally 1125.
// R05 - Every frame has exactly 1080 active lines. The code ends a frame cut by a video stop after its current line.
// R06 - Vertical blanking lasts 35 to 59 lines, nominally 45.
// R07 - Horizontal total is 2100 to 2300 units, nominally 2200.
// R08 - Every line has exactly 1920 active units with data enable high.
// R09 - Horizontal blanking lasts 180 to 380 units, nominally 280.
// R10 - With panel supply off, every interface input is low, never high.
// R11 - With panel supply on, every interface signal is actively driven.
// R12 - Backlight on only after panel runs; panel off only after backlight off.
// R13 - Two pixels per link clock, even first, odd second, from frame start.
// R14 - Overdrive select low for 60 Hz frames, high for 50 Hz frames.
// R15 - Panel finds line and frame edges only from data enable.
// R16 - Data enable low in all blanking; link clock keeps running.
package panel_timing_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // System clock and power sequence times.
    localparam int CLOCK_HZ           = 10_000_000;
    localparam int CYCLES_PER_MS      = CLOCK_HZ / 1000;
    localparam int SUPPLY_RAMP_MS     = 20;
    localparam int BACKLIGHT_DARK_MS  = 10;
    localparam int VIDEO_STOP_MS      = 10;
    localparam int DISCHARGE_MS       = 500;
    localparam int SUPPLY_RAMP_CYCLES    = SUPPLY_RAMP_MS * CYCLES_PER_MS;
    localparam int BACKLIGHT_DARK_CYCLES = BACKLIGHT_DARK_MS * CYCLES_PER_MS;
    localparam int VIDEO_STOP_CYCLES     = VIDEO_STOP_MS * CYCLES_PER_MS;
    localparam int DISCHARGE_CYCLES      = DISCHARGE_MS * CYCLES_PER_MS;
    localparam int VIDEO_LEAD_FRAMES  = 3;
    localparam int TIMER_WIDTH        = 24;
    localparam int FRAME_COUNT_WIDTH  = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock and frame rate limits.
    localparam int LINK_MHZ_MIN       = 60;
    localparam int LINK_MHZ_TYP       = 74;
    localparam int LINK_MHZ_MAX       = 80;
    localparam int RATE_FIFTY_MIN     = 47;
    localparam int RATE_FIFTY_TYP     = 50;
    localparam int RATE_FIFTY_MAX     = 53;
    localparam int RATE_SIXTY_MIN     = 57;
    localparam int RATE_SIXTY_TYP     = 60;
    localparam int RATE_SIXTY_MAX     = 63;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame geometry in lines and in pixel units.
    localparam int V_ACTIVE           = 1080;
    localparam int V_BLANK_MIN        = 35;
    localparam int V_BLANK_TYP        = 45;
    localparam int V_BLANK_MAX        = 59;
    localparam int V_TOTAL_MIN        = 1115;
    localparam int V_TOTAL_TYP        = 1125;
    localparam int V_TOTAL_MAX        = 1139;
    localparam int H_ACTIVE           = 1920;
    localparam int H_BLANK_MIN        = 180;
    localparam int H_BLANK_TYP        = 280;
    localparam int H_BLANK_MAX        = 380;
    localparam int H_TOTAL_MIN        = 2100;
    localparam int H_TOTAL_TYP        = 2200;
    localparam int H_TOTAL_MAX        = 2300;
    localparam int PIXELS_PER_CLOCK   = 2;
    localparam int COUNT_WIDTH        = 12;
    localparam int COLOR_WIDTH        = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Pixel carriers.
    typedef struct packed {
        logic [COLOR_WIDTH-1:0] red;
        logic [COLOR_WIDTH-1:0] green;
        logic [COLOR_WIDTH-1:0] blue;
    } pixel_type;

    typedef struct packed {
        pixel_type even;
        pixel_type odd;
    } pixel_pair_type;

    typedef struct packed {
        logic           de;
        pixel_pair_type pair;
    } link_word_type;

endpackage

// ==== src/event_cross.sv ====
`timescale 1ns/1ps
module event_cross
(
    // Source domain.
    input  wire logic src_clock,
    input  wire logic src_reset,
    input  wire logic src_pulse,
    // Destination domain.
    input  wire logic dst_clock,
    input  wire logic dst_reset,
    output logic      dst_pulse
);

    logic toggle_r;
    logic sync_r;
    logic seen_r;
    logic last_r;

    // Each source pulse flips a level that crosses safely.
    always_ff @(posedge src_clock)
    begin
        if (src_reset)
            toggle_r <= 1'b0;
        else if (src_pulse)
            toggle_r <= ~toggle_r;
    end

    always_ff @(posedge dst_clock)
    begin
        if (dst_reset)
        begin
            sync_r <= 1'b0;
            seen_r <= 1'b0;
            last_r <= 1'b0;
        end
        else
        begin
            sync_r <= toggle_r;
            seen_r <= sync_r;
            last_r <= seen_r;
        end
    end

    assign dst_pulse = seen_r ^ last_r;

endmodule

// ==== src/level_sync.sv ====
`timescale 1ns/1ps
module level_sync
#(
    parameter int WIDTH = 1
)
(
    // Destination clock.
    input  wire logic             clock,
    // Levels from another domain and their synchronised copy.
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage_r;

    // Two flip-flops; only the second one is read outside.
    always_ff @(posedge clock)
    begin
        stage_r   <= level_in;
        level_out <= stage_r;
    end

endmodule

// ==== src/panel_video_host.sv ====
`timescale 1ns/1ps
module panel_video_host
    import panel_timing_pkg::*;
#(
    parameter int H_BLANK               = H_BLANK_TYP,
    parameter int V_BLANK               = V_BLANK_TYP,
    parameter int SUPPLY_RAMP_TIME      = SUPPLY_RAMP_CYCLES,
    parameter int BACKLIGHT_DARK_TIME   = BACKLIGHT_DARK_CYCLES,
    parameter int VIDEO_STOP_TIME       = VIDEO_STOP_CYCLES,
    parameter int DISCHARGE_TIME        = DISCHARGE_CYCLES,
    parameter int LEAD_FRAMES           = VIDEO_LEAD_FRAMES
)
(
    // System clock and reset.
    input  wire logic          clock,
    input  wire logic          reset,
    // Link clock from the pixel clock source.
    input  wire logic          link_clock,
    // User control, system domain.
    input  wire logic          display_on_request,
    input  wire logic          frame_rate_fifty,
    // User status, system domain.
    output logic               panel_ready,
    output logic               sequence_busy,
    // Pixel source, link domain.
    output logic               pixel_request,
    output logic               frame_first,
    input  wire pixel_pair_type pixel_in,
    // Panel supply and backlight, system domain.
    output logic               panel_supply_on,
    output logic               backlight_on,
    // Panel link, link domain.
    output logic               transmitter_enable,
    output link_word_type      link_out,
    output logic               overdrive_table_select
);

    ////////////////////////////////////////////////////////////////////////////////
    // Geometry kept inside the legal windows.

    function automatic int clamp(input int value, input int low, input int high);
        int result;
        result = value;
        if (value < low)
            result = low;
        else if (value > high)
            result = high;
        return result;
    endfunction

    localparam int H_BLANK_USED = clamp(H_BLANK, H_BLANK_MIN, H_BLANK_MAX);
    localparam int V_BLANK_USED = clamp(V_BLANK, V_BLANK_MIN, V_BLANK_MAX);
    localparam int H_TOTAL_USED = clamp(H_ACTIVE + H_BLANK_USED, H_TOTAL_MIN, H_TOTAL_MAX);
    localparam int V_TOTAL_USED = clamp(V_ACTIVE + V_BLANK_USED, V_TOTAL_MIN, V_TOTAL_MAX);

    localparam logic [COUNT_WIDTH-1:0] H_ACTIVE_CLOCKS =
        COUNT_WIDTH'(H_ACTIVE / PIXELS_PER_CLOCK);
    localparam logic [COUNT_WIDTH-1:0] H_LAST =
        COUNT_WIDTH'(H_TOTAL_USED / PIXELS_PER_CLOCK - 1);
    localparam logic [COUNT_WIDTH-1:0] V_ACTIVE_LINES = COUNT_WIDTH'(V_ACTIVE);
    localparam logic [COUNT_WIDTH-1:0] V_LAST = COUNT_WIDTH'(V_TOTAL_USED - 1);
    localparam logic [TIMER_WIDTH-1:0] RAMP_LOAD  = TIMER_WIDTH'(SUPPLY_RAMP_TIME - 1);
    localparam logic [TIMER_WIDTH-1:0] DARK_LOAD  = TIMER_WIDTH'(BACKLIGHT_DARK_TIME - 1);
    localparam logic [TIMER_WIDTH-1:0] STOP_LOAD  = TIMER_WIDTH'(VIDEO_STOP_TIME - 1);
    localparam logic [TIMER_WIDTH-1:0] DRAIN_LOAD = TIMER_WIDTH'(DISCHARGE_TIME - 1);
    localparam logic [FRAME_COUNT_WIDTH-1:0] LEAD_COUNT = FRAME_COUNT_WIDTH'(LEAD_FRAMES);

    ////////////////////////////////////////////////////////////////////////////////
    // Power sequence states, system domain.

    typedef enum logic [6:0] {
        POWER_OFF      = 7'h01,
        SUPPLY_RAMP    = 7'h02,
        VIDEO_SETTLE   = 7'h04,
        LIT            = 7'h08,
        BACKLIGHT_DARK = 7'h10,
        VIDEO_STOP     = 7'h20,
        DISCHARGE      = 7'h40
    } power_state_type;

    power_state_type                state_r;
    power_state_type                state_nxt;
    logic [TIMER_WIDTH-1:0]         timer_r;
    logic [TIMER_WIDTH-1:0]         timer_nxt;
    logic                           timer_load;
    logic                           timer_done;
    logic [FRAME_COUNT_WIDTH-1:0]   frames_r;
    logic                           supply_r;
    logic                           video_run_r;
    logic                           backlight_r;
    logic                           frame_seen;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain signals.

    logic [2:0]                     link_levels;
    logic                           link_reset;
    logic                           run_link;
    logic                           fifty_link;
    logic                           live;
    logic [COUNT_WIDTH-1:0]         h_r;
    logic [COUNT_WIDTH-1:0]         v_r;
    logic                           active;
    logic                           frame_start;
    link_word_type                  link_r;
    logic                           select_r;
    logic                           tx_en_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequence decisions.

    assign timer_done = (timer_r == '0);

    always_comb
    begin
        state_nxt  = state_r;
        timer_load = 1'b0;
        timer_nxt  = '0;
        unique case (state_r)
            POWER_OFF:
            begin
                if (display_on_request)
                begin
                    state_nxt  = SUPPLY_RAMP;
                    timer_load = 1'b1;
                    timer_nxt  = RAMP_LOAD;
                end
            end
            SUPPLY_RAMP:
            begin
                if (timer_done)
                    state_nxt = VIDEO_SETTLE;
            end
            VIDEO_SETTLE:
            begin
                if (!display_on_request)
                begin
                    state_nxt  = VIDEO_STOP;
                    timer_load = 1'b1;
                    timer_nxt  = STOP_LOAD;
                end
                else if (frames_r >= LEAD_COUNT)
                    state_nxt = LIT; // [R12]
            end
            LIT:
            begin
                if (!display_on_request)
                begin
                    state_nxt  = BACKLIGHT_DARK;
                    timer_load = 1'b1;
                    timer_nxt  = DARK_LOAD;
                end
            end
            BACKLIGHT_DARK:
            begin
                if (timer_done)
                begin
                    state_nxt  = VIDEO_STOP; // [R12]
                    timer_load = 1'b1;
                    timer_nxt  = STOP_LOAD;
                end
            end
            VIDEO_STOP:
            begin
                if (timer_done)
                begin
                    state_nxt  = DISCHARGE;
                    timer_load = 1'b1;
                    timer_nxt  = DRAIN_LOAD;
                end
            end
            DISCHARGE:
            begin
                if (timer_done)
                    state_nxt = POWER_OFF;
            end
            default:
            begin
                state_nxt = POWER_OFF;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            state_r <= POWER_OFF;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            timer_r <= '0;
        else if (timer_load)
            timer_r <= timer_nxt;
        else if (!timer_done)
            timer_r <= timer_r - 1'b1;
    end

    // Frames sent since the video started; gates the backlight.
    always_ff @(posedge clock)
    begin
        if (reset || state_r != VIDEO_SETTLE)
            frames_r <= '0;
        else if (frame_seen && frames_r < LEAD_COUNT)
            frames_r <= frames_r + 1'b1; // [R12]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Supply, video and backlight levels.

    always_ff @(posedge clock)
    begin
        if (reset)
            supply_r <= 1'b0;
        else
            supply_r <= (state_nxt != POWER_OFF) && (state_nxt != DISCHARGE);
    end

    // Video runs only between supply ramp and supply off.
    always_ff @(posedge clock)
    begin
        if (reset)
            video_run_r <= 1'b0;
        else
            video_run_r <= (state_nxt == VIDEO_SETTLE) || (state_nxt == LIT)
                           || (state_nxt == BACKLIGHT_DARK); // [R10] [R11]
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            backlight_r <= 1'b0;
        else
            backlight_r <= (state_nxt == LIT); // [R12]
    end

    assign panel_supply_on = supply_r;
    assign backlight_on    = backlight_r;
    assign panel_ready     = backlight_r;
    assign sequence_busy   = (state_r != POWER_OFF) && (state_r != LIT);

    ////////////////////////////////////////////////////////////////////////////////
    // Crossings between the two domains.

    level_sync #(
        .WIDTH     (3)
    ) link_sync (
        .clock     (link_clock),
        .level_in  ({reset, video_run_r, frame_rate_fifty}),
        .level_out (link_levels)
    );

    assign link_reset = link_levels[2];
    assign run_link   = link_levels[1];
    assign fifty_link = link_levels[0];

    // A started active period runs to its end, so a stop never cuts a line short.
    assign live       = run_link
                        || ((h_r != '0) && (h_r < H_ACTIVE_CLOCKS)); // [R08]

    event_cross frame_cross (
        .src_clock (link_clock),
        .src_reset (link_reset),
        .src_pulse (frame_start),
        .dst_clock (clock),
        .dst_reset (reset),
        .dst_pulse (frame_seen)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Line and frame counters, two pixel units per link clock.

    always_ff @(posedge link_clock)
    begin
        if (link_reset || !live)
            h_r <= '0;
        else if (h_r == H_LAST)
            h_r <= '0; // [R07] [R09]
        else
            h_r <= h_r + 1'b1;
    end

    always_ff @(posedge link_clock)
    begin
        if (link_reset || !live)
            v_r <= '0;
        else if (h_r == H_LAST)
        begin
            if (v_r == V_LAST)
                v_r <= '0; // [R04] [R06]
            else
                v_r <= v_r + 1'b1;
        end
    end

    // Active only inside the 1920 by 1080 area; blanking keeps enable low.
    assign active        = live && (h_r < H_ACTIVE_CLOCKS)
                           && (v_r < V_ACTIVE_LINES); // [R05] [R08] [R16] [R15]
    assign frame_start   = live && (h_r == '0) && (v_r == '0);
    assign pixel_request = active;
    assign frame_first   = active && frame_start; // [R13]

    ////////////////////////////////////////////////////////////////////////////////
    // Link outputs, low whenever video is stopped.

    always_ff @(posedge link_clock)
    begin
        if (link_reset || !live)
            link_r <= '0; // [R10]
        else
        begin
            link_r.de   <= active; // [R16]
            link_r.pair <= active ? pixel_in : '0; // [R13]
        end
    end

    // Table select follows the frame rate, loaded only at a frame start and cleared when video stops.
    always_ff @(posedge link_clock)
    begin
        if (link_reset || !live)
            select_r <= 1'b0; // [R10]
        else if (frame_start)
            select_r <= fifty_link; // [R14] [R02] [R03]
    end

    // The transmitter runs from the link clock whenever video is on.
    always_ff @(posedge link_clock)
    begin
        if (link_reset)
            tx_en_r <= 1'b0;
        else
            tx_en_r <= live; // [R01] [R11]
    end

    assign link_out               = link_r;
    assign overdrive_table_select = select_r;
    assign transmitter_enable     = tx_en_r;

endmodule

// ==== verif/panel_model.sv ====
`timescale 1ns/1ps
module panel_model
    import panel_timing_pkg::*;
(
    // Link from the host.
    input wire logic          link_clock,
    input wire link_word_type link_out,
    // Geometry of the last line, one pulse a line except for the last line of each frame.
    output logic              line_done,
    output int                line_active,
    output int                line_blank
);
    logic prev_r   = 1'b0;
    int   active_r = 0;
    int   idle_r   = H_TOTAL_MAX;
    always_ff @(posedge link_clock)
    begin
        line_done <= 1'b0;
        prev_r    <= link_out.de;
        if (link_out.de === 1'b1 && !prev_r)
        begin
            // Only data enable edges mark lines; a long low run is vertical blanking.
            line_done   <= idle_r <= H_BLANK_MAX / PIXELS_PER_CLOCK;
            line_active <= active_r * PIXELS_PER_CLOCK;
            line_blank  <= idle_r * PIXELS_PER_CLOCK;
            active_r    <= 1;
            idle_r      <= 0;
        end
        else if (link_out.de === 1'b1)
            active_r <= active_r + 1;
        else
            idle_r <= idle_r + 1;
    end
endmodule

// ==== verif/panel_video_host_asserts.sv ====
`timescale 1ns/1ps
module panel_video_host_asserts
    import panel_timing_pkg::*;
#(
    parameter int H_BLANK = H_BLANK_TYP
)
(
    // Clocks and reset.
    input wire logic           clock,
    input wire logic           reset,
    input wire logic           link_clock,
    // Observed ports.
    input wire logic           display_on_request,
    input wire logic           sequence_busy,
    input wire logic           pixel_request,
    input wire logic           frame_first,
    input wire pixel_pair_type pixel_in,
    input wire logic           panel_supply_on,
    input wire logic           backlight_on,
    input wire logic           transmitter_enable,
    input wire link_word_type  link_out,
    input wire logic           overdrive_table_select
);
    int run_r;
    int idle_r;
    ////////////////////////////////////////////////////////////
    always_ff @(posedge link_clock)
    begin
        run_r <= link_out.de ? run_r + 1 : 0;
    end
    always_ff @(posedge link_clock)
    begin
        idle_r <= link_out.de ? 0 : idle_r + 1;
    end
    ////////////////////////////////////////////////////////////
    AST_QUIET_WHEN_OFF: assert property (@(posedge link_clock) disable iff (reset)
        !panel_supply_on |-> link_out == '0 && !overdrive_table_select)
        else $error("link driven while supply off");
    AST_ACTIVE_RUN: assert property (@(posedge link_clock) disable iff (reset)
        $fell(link_out.de) |-> run_r == H_ACTIVE / PIXELS_PER_CLOCK)
        else $error("wrong active run length");
    AST_LINE_BLANK: assert property (@(posedge link_clock) disable iff (reset)
        $rose(link_out.de) && !$past(frame_first) |-> idle_r == H_BLANK / PIXELS_PER_CLOCK)
        else $error("wrong line blank length");
    AST_PAIR_FOLLOWS: assert property (@(posedge link_clock) disable iff (reset)
        pixel_request |=> link_out.de && link_out.pair == $past(pixel_in))
        else $error("pair not sent one cycle later");
    AST_DE_LOW_IDLE: assert property (@(posedge link_clock) disable iff (reset)
        !pixel_request |=> !link_out.de)
        else $error("enable high without request");
    AST_FIRST_IN_REQ: assert property (@(posedge link_clock) disable iff (reset)
        frame_first |-> pixel_request)
        else $error("frame mark outside request");
    AST_SELECT_AT_FRAME: assert property (@(posedge link_clock) disable iff (reset)
        $changed(overdrive_table_select) && transmitter_enable |-> $past(frame_first))
        else $error("table select changed mid frame");
    AST_LIGHT_NEEDS_VIDEO: assert property (@(posedge clock) disable iff (reset)
        backlight_on |-> panel_supply_on && transmitter_enable)
        else $error("backlight on without running panel");
    AST_DARK_FIRST: assert property (@(posedge clock) disable iff (reset)
        backlight_on && !display_on_request |=> !backlight_on)
        else $error("backlight not off first");
    AST_SUPPLY_ANSWER: assert property (@(posedge clock) disable iff (reset)
        !sequence_busy && !panel_supply_on && display_on_request |=> panel_supply_on)
        else $error("supply did not start");
    AST_SUPPLY_LAST: assert property (@(posedge clock) disable iff (reset)
        $fell(panel_supply_on) |-> !backlight_on && !transmitter_enable)
        else $error("supply off before backlight and video");
    COV_LINE: cover property (@(posedge link_clock) disable iff (reset) $fell(link_out.de));
    COV_LIT: cover property (@(posedge clock) disable iff (reset) $rose(backlight_on));
    COV_FIFTY: cover property (@(posedge link_clock) disable iff (reset)
        $rose(overdrive_table_select));
endmodule
bind panel_video_host panel_video_host_asserts #(.H_BLANK(H_BLANK)) u_asserts (.clock, .reset,
    .link_clock, .display_on_request, .sequence_busy, .pixel_request, .frame_first, .pixel_in,
    .panel_supply_on, .backlight_on, .transmitter_enable, .link_out, .overdrive_table_select);

// ==== verif/panel_video_host_tb.sv ====
`timescale 1ns/1ps
module panel_video_host_tb;
    import panel_timing_pkg::*;
    logic           clock = 1'b0;
    logic           link_clock = 1'b0;
    logic           reset = 1'b1;
    logic           display_on_request = 1'b0;
    logic           frame_rate_fifty = 1'b0;
    pixel_pair_type pixel_in = '0;
    logic           panel_ready, sequence_busy, pixel_request, frame_first;
    logic           panel_supply_on, backlight_on, transmitter_enable, overdrive_table_select;
    link_word_type  link_out;
    logic           line_done;
    int             line_active, line_blank;
    int             fails = 0;
    int             checks = 0;
    int             seed = 32'h9e35;
    int             lines = 0;
    int             sel_wait = 0;
    bit             first_exp, fifty_exp;
    logic [63:0]    rnd;
    pixel_pair_type sent_q[$];

    always #50 clock = ~clock;
    initial #3 forever #7.5 link_clock = ~link_clock;

    panel_video_host #(.H_BLANK(H_BLANK_MIN), .SUPPLY_RAMP_TIME(20), .BACKLIGHT_DARK_TIME(20),
        .VIDEO_STOP_TIME(200), .DISCHARGE_TIME(20), .LEAD_FRAMES(1)) u_dut (.clock, .reset,
        .link_clock, .display_on_request, .frame_rate_fifty, .panel_ready, .sequence_busy,
        .pixel_request, .frame_first, .pixel_in, .panel_supply_on, .backlight_on,
        .transmitter_enable, .link_out, .overdrive_table_select);
    panel_model u_panel (.link_clock, .link_out, .line_done, .line_active, .line_blank);
    ////////////////////////////////////////////////////////////
    task automatic fail_line(input string what, input string exp, input string got);
        fails++;
        $display("CHECK FAILED %s expected %s seen %s", what, exp, got);
    endtask
    task automatic compare_int(input string what, input int exp, input int got);
        checks++;
        if (exp != got)
            fail_line(what, $sformatf("%0d", exp), $sformatf("%0d", got));
    endtask
    task automatic compare_bit(input string what, input logic exp, input logic got);
        checks++;
        if (exp !== got)
            fail_line(what, $sformatf("%b", exp), $sformatf("%b", got));
    endtask
    task automatic compare_pair(input string what, input pixel_pair_type exp,
                                input pixel_pair_type got);
        checks++;
        if (exp !== got)
            fail_line(what, $sformatf("%h", exp), $sformatf("%h", got));
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge link_clock)
    begin
        if (sel_wait == 1)
            compare_bit("table select", fifty_exp, overdrive_table_select);
        if (sel_wait > 0)
            sel_wait--;
        if (link_out.de === 1'b1)
            compare_pair("pair", sent_q.pop_front(), link_out.pair);
        if (pixel_request === 1'b1)
        begin
            compare_bit("frame first", first_exp, frame_first);
            if (first_exp)
                sel_wait = 2;
            first_exp = 1'b0;
            sent_q.push_back(pixel_in);
        end
        if (line_done === 1'b1)
        begin
            compare_int("active", H_ACTIVE, line_active);
            compare_int("blank", H_BLANK_MIN, line_blank);
            compare_int("total", H_TOTAL_MIN, line_active + line_blank);
            lines++;
        end
        #1 rnd = {$random(seed), $random(seed)};
        pixel_in = rnd[47:0];
    end

    task automatic power_cycle(input bit bounce, input bit fifty);
        int i;
        fifty_exp = fifty;
        first_exp = 1'b1;
        lines = 0;
        #1 display_on_request = 1'b1;
        frame_rate_fifty = fifty;
        repeat (2) @(posedge clock);
        #1 compare_bit("supply", 1'b1, panel_supply_on);
        if (bounce)
        begin
            #1 display_on_request = 1'b0;
            repeat (3) @(posedge clock);
            #1 display_on_request = 1'b1;
            compare_bit("supply held", 1'b1, panel_supply_on);
        end
        for (i = 0; i < 2000 && backlight_on !== 1'b1; i++) @(posedge clock);
        compare_bit("video before light", 1'b1, transmitter_enable);
        compare_bit("ready", 1'b1, panel_ready);
        for (i = 0; i < 5000 && lines < 3; i++) @(posedge clock);
        compare_int("lines", 3, lines);
        #1 display_on_request = 1'b0;
        repeat (2) @(posedge clock);
        #1 compare_bit("light off", 1'b0, backlight_on);
        compare_bit("ready off", 1'b0, panel_ready);
        compare_bit("video kept", 1'b1, transmitter_enable);
        for (i = 0; i < 500 && (sequence_busy !== 1'b0 || panel_supply_on !== 1'b0); i++)
            @(posedge clock);
        #1 compare_bit("supply off", 1'b0, panel_supply_on);
        compare_bit("enable low", 1'b0, link_out.de);
        compare_bit("select low", 1'b0, overdrive_table_select);
        compare_int("pairs left", 0, sent_q.size());
    endtask

    initial
    begin
        int r;
        repeat (5) @(posedge clock);
        #1 reset = 1'b0;
        r = $random(seed);
        for (int pass = 0; pass < 3; pass++)
        begin
            @(posedge clock);
            power_cycle(pass == 1, r[0] ^ pass[0]);
        end
        print_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        print_verdict();
    end
endmodule
